// [verilog/cbs_device.sv]
// Device end: balance setup, 13-location pattern store, auto stepping,
// watchdog, sleep and wake. Assumes host keeps its own sequencing.
//
// Function
// - Thirteen pattern locations, one reachable at once
// - Pattern index selects accessed location
// - Setup bits: run, index, gap, kind
// - Kind codes: off, manual, timed, auto
// - Host keeps index zero outside auto
// - Auto steps index once per gap plus one second through 12
// - All-zero location in auto returns to 1
// - Host programs kind, index, cells, then run
// - Host stops by clearing run
// - Enable and inhibit accepted when broadcast
// - Lost link starts watchdog countdown
// - Watchdog expiry in manual stops, sleeps
// - Wake resumes manual balance held before a sleep command
// - Sleep without watchdog stops balance at once
// - Sleep with watchdog: flag set on expiry
// - Pattern bit n drives cell n+1 switch
// - Enable command sets run, inhibit clears
`timescale 1ns/1ns
`default_nettype none
module cbs_device
	import cbs_pkg::*;
#(
	parameter int WDOG_CYCLES = WDOG_DEF_CYCLES,
	parameter int SEC_CNT = SEC_CYCLES
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Link
	cbs_link_if.dev link,
	// Watchdog control
	input wire logic wdog_on,
	// Outputs
	output logic [CELLS-1:0] cell_drain,
	output logic asleep,
	output logic watchdog_expired_flag
);
	// ************************************************************
	// State
	// ************************************************************
	logic [CELLS-1:0] pat_q [LOCS];
	logic balance_run_q;
	logic [3:0] pattern_index_q;
	logic [2:0] cycle_gap_sel_q;
	logic [1:0] balance_kind_q;
	logic sleep_q;
	logic [31:0] wdog_q;
	logic [31:0] gap_q;
	logic [CELLS-1:0] drain_q;
	logic wdt_flag_q;
	logic [CELLS-1:0] rdata_q;
	logic rvalid_q;
	// ************************************************************
	// Decode
	// ************************************************************
	wire logic idx_ok = pattern_index_q <= IDX_LAST;
	wire logic [CELLS-1:0] cur_pat = idx_ok ? pat_q[pattern_index_q] : PATTERN_RST;
	wire logic [SETUP_W-1:0] setup_rd = {balance_run_q, pattern_index_q,
		cycle_gap_sel_q, balance_kind_q};
	wire logic kind_manual = balance_kind_q == KIND_MANUAL;
	wire logic kind_timed = balance_kind_q == KIND_TIMED;
	wire logic kind_auto = balance_kind_q == KIND_AUTO;
	wire logic cmd_en = link.cmd == CMD_BAL_ENABLE;
	wire logic cmd_inh = link.cmd == CMD_BAL_INHIBIT;
	wire logic cmd_sleep = link.cmd == CMD_SLEEP;
	wire logic cmd_wake = link.cmd == CMD_WAKE;
	wire logic wr_setup = link.wr_en && link.addr == ADDR_SETUP;
	wire logic wr_pat = link.wr_en && link.addr == ADDR_PATTERN && idx_ok;
	wire logic wdog_run = wdog_on && !link.link_alive;
	wire logic wdog_done = wdog_run && wdog_q == 32'h0;
	// Gap length in cycles: code 0 is one cycle, else 2^(code-1) seconds
	wire logic [31:0] gap_len = (cycle_gap_sel_q == 3'h0) ? 32'h1 :
		32'(SEC_CNT) << (cycle_gap_sel_q - 3'h1);
	wire logic auto_tick = kind_auto && balance_run_q && !sleep_q && gap_q == 32'h0;
	wire logic [3:0] idx_next = (pattern_index_q >= IDX_LAST) ? IDX_FIRST_AUTO :
		pattern_index_q + 4'h1;
	wire logic [CELLS-1:0] nxt_pat = (idx_next <= IDX_LAST) ? pat_q[idx_next] : PATTERN_RST;
	wire logic [3:0] idx_step = (nxt_pat == PATTERN_RST) ? IDX_FIRST_AUTO : idx_next;
	// Manual, timed and auto all drive from the current location; off drives nothing
	wire logic drive_on = balance_run_q && !sleep_q &&
		(kind_manual || kind_timed || kind_auto);
	wire logic [CELLS-1:0] drain_d = drive_on ? cur_pat : PATTERN_RST;
	// ************************************************************
	// Pattern store
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < LOCS; gi++)
		begin : g_loc
			always_ff @(posedge mclk or negedge rst_b)
			begin
				if (!rst_b)
					pat_q[gi] <= PATTERN_RST;
				else if (clk_en && wr_pat && pattern_index_q == 4'(gi))
					pat_q[gi] <= link.wdata;
			end
		end
	endgenerate
	// ************************************************************
	// Setup register and commands
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			balance_run_q <= SETUP_RST[RUN_BIT];
			pattern_index_q <= SETUP_RST[IDX_MSB:IDX_LSB];
			cycle_gap_sel_q <= SETUP_RST[GAP_MSB:GAP_LSB];
			balance_kind_q <= SETUP_RST[KIND_MSB:KIND_LSB];
		end
		else if (clk_en)
		begin
			if (wr_setup)
			begin
				balance_run_q <= link.wdata[RUN_BIT];
				pattern_index_q <= link.wdata[IDX_MSB:IDX_LSB];
				cycle_gap_sel_q <= link.wdata[GAP_MSB:GAP_LSB];
				balance_kind_q <= link.wdata[KIND_MSB:KIND_LSB];
			end
			else if (auto_tick)
				pattern_index_q <= idx_step;
			if (cmd_en)
				balance_run_q <= 1'b1;
			else if (cmd_inh)
				balance_run_q <= 1'b0;
			else if (wdog_done && kind_manual)
				balance_run_q <= 1'b0;
		end
	end
	// ************************************************************
	// Sleep, watchdog, auto gap timer
	// ************************************************************
	// Run bit survives a sleep command so wake resumes manual balancing; watchdog expiry in manual clears it
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			sleep_q <= 1'b0;
		else if (clk_en)
		begin
			if (cmd_wake)
				sleep_q <= 1'b0;
			else if (cmd_sleep || (wdog_done && kind_manual))
				sleep_q <= 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		// Full count at reset: host shows the link as lost until its first edge
		if (!rst_b)
			wdog_q <= 32'(WDOG_CYCLES - 1);
		else if (clk_en)
		begin
			if (!wdog_run)
				wdog_q <= 32'(WDOG_CYCLES - 1);
			else if (wdog_q != 32'h0)
				wdog_q <= wdog_q - 32'h1;
		end
	end
	// Flag is sticky until reset; set on expiry asleep or awake
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			wdt_flag_q <= 1'b0;
		else if (clk_en && wdog_done)
			wdt_flag_q <= 1'b1;
	end
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			gap_q <= 32'h0;
		else if (clk_en)
		begin
			if (!(kind_auto && balance_run_q))
				gap_q <= 32'h0;
			else if (auto_tick)
				gap_q <= gap_len + 32'(SEC_CNT) - 32'h1;
			else if (!sleep_q && gap_q != 32'h0)
				gap_q <= gap_q - 32'h1;
		end
	end
	// ************************************************************
	// Outputs and read path
	// ************************************************************
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drain_q <= PATTERN_RST;
			rdata_q <= PATTERN_RST;
			rvalid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			drain_q <= drain_d;
			rvalid_q <= link.rd_en;
			if (link.rd_en)
				rdata_q <= (link.addr == ADDR_SETUP) ? {2'h0, setup_rd} : cur_pat;
		end
	end
	assign cell_drain = drain_q;
	assign asleep = sleep_q;
	assign watchdog_expired_flag = wdt_flag_q;
	assign link.rdata = rdata_q;
	assign link.rvalid = rvalid_q;
endmodule : cbs_device
`default_nettype wire

// [verilog/cbs_pkg.sv]
// Constants shared by both ends of the cell balance control link.
// Assumes one 50 MHz clock common to host and device logic.
package cbs_pkg;
	// ************************************************************
	// Register layout
	// ************************************************************
	localparam int SETUP_W = 10;
	localparam int CELLS = 12;
	localparam int LOCS = 13;
	localparam int RUN_BIT = 9;
	localparam int IDX_LSB = 5;
	localparam int IDX_MSB = 8;
	localparam int GAP_LSB = 2;
	localparam int GAP_MSB = 4;
	localparam int KIND_LSB = 0;
	localparam int KIND_MSB = 1;
	localparam logic [SETUP_W-1:0] SETUP_RST = 10'h000;
	localparam logic [CELLS-1:0] PATTERN_RST = 12'h000;
	localparam logic [3:0] IDX_FIRST_AUTO = 4'h1;
	localparam logic [3:0] IDX_LAST = 4'hc;
	// Register selector on the link
	localparam logic ADDR_SETUP = 1'b0;
	localparam logic ADDR_PATTERN = 1'b1;
	// ************************************************************
	// Balance kinds and commands
	// ************************************************************
	typedef enum logic [1:0] {
		KIND_OFF = 2'h0,
		KIND_MANUAL = 2'h1,
		KIND_TIMED = 2'h2,
		KIND_AUTO = 2'h3
	} cbs_kind_t;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0,
		CMD_BAL_ENABLE = 3'h1,
		CMD_BAL_INHIBIT = 3'h2,
		CMD_SLEEP = 3'h3,
		CMD_WAKE = 3'h4
	} cbs_cmd_t;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int SEC_CYCLES = CLK_HZ;
	localparam int WDOG_DEF_CYCLES = SEC_CYCLES;
	// Gap codes 0,1,2,4,8,16,32,64 seconds
	localparam logic [6:0] GAP_SEC_0 = 7'h00;
endpackage : cbs_pkg

// [verilog/cbs_link_if.sv]
// Link between host and device: register access and commands.
// Assumes both ends on mclk; a request is one-cycle valid.
`timescale 1ns/1ns
`default_nettype none
interface cbs_link_if;
	import cbs_pkg::*;
	logic wr_en;
	logic rd_en;
	logic addr;
	logic [CELLS-1:0] wdata;
	logic [CELLS-1:0] rdata;
	logic rvalid;
	logic [2:0] cmd;
	logic bcast;
	logic link_alive;
	modport host (output wr_en, rd_en, addr, wdata, cmd, bcast, link_alive,
		input rdata, rvalid);
	modport dev (input wr_en, rd_en, addr, wdata, cmd, bcast, link_alive,
		output rdata, rvalid);
endinterface : cbs_link_if
`default_nettype wire

// [verilog/cbs_host.sv]
// Host end: turns user requests into link writes, reads and commands.
// Assumes the device answers a read one cycle later.
`timescale 1ns/1ns
`default_nettype none
module cbs_host
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// User requests
	input wire logic req_wr,
	input wire logic req_rd,
	input wire logic req_addr,
	input wire logic [CELLS-1:0] req_wdata,
	input wire logic [2:0] req_cmd,
	input wire logic req_bcast,
	input wire logic comm_ok,
	// User answers
	output logic [CELLS-1:0] rsp_data,
	output logic rsp_valid,
	// Link
	cbs_link_if.host link
);
	logic wr_q;
	logic rd_q;
	logic addr_q;
	logic [CELLS-1:0] wdata_q;
	logic [2:0] cmd_q;
	logic bcast_q;
	logic alive_q;
	logic [CELLS-1:0] rsp_q;
	logic rsp_v_q;
	// User sequencing keeps index zero outside auto and run set last
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= ADDR_SETUP;
			wdata_q <= PATTERN_RST;
			cmd_q <= CMD_NONE;
			bcast_q <= 1'b0;
			alive_q <= 1'b0;
			rsp_q <= PATTERN_RST;
			rsp_v_q <= 1'b0;
		end
		else if (clk_en)
		begin
			wr_q <= req_wr;
			rd_q <= req_rd && !req_wr;
			addr_q <= req_addr;
			wdata_q <= req_wdata;
			cmd_q <= req_cmd;
			bcast_q <= req_bcast;
			alive_q <= comm_ok;
			rsp_v_q <= link.rvalid;
			if (link.rvalid)
				rsp_q <= link.rdata;
		end
	end
	assign link.wr_en = wr_q;
	assign link.rd_en = rd_q;
	assign link.addr = addr_q;
	assign link.wdata = wdata_q;
	assign link.cmd = cmd_q;
	assign link.bcast = bcast_q;
	assign link.link_alive = alive_q;
	assign rsp_data = rsp_q;
	assign rsp_valid = rsp_v_q;
endmodule : cbs_host
`default_nettype wire

// [tb/cbs_link_sva.sv]
// Checker on the host-device balance link and device outputs.
// Assumes one clock; instantiated in tb beside the link.
`timescale 1ns/1ns
`default_nettype none
module cbs_link_sva
	import cbs_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Link
	input wire logic rd_en,
	input wire logic addr,
	input wire logic [CELLS-1:0] rdata,
	input wire logic rvalid,
	input wire logic [2:0] cmd,
	// Device outputs
	input wire logic [CELLS-1:0] cell_drain,
	input wire logic asleep,
	input wire logic watchdog_expired_flag
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_read_answer_next: assert property (rd_en |=> rvalid)
		else $error("read not answered next cycle");
	a_rvalid_has_cause: assert property (rvalid |-> $past(rd_en))
		else $error("answer without read");
	a_setup_top_zero: assert property (rd_en && addr == ADDR_SETUP |=> rdata[11:10] == 2'h0)
		else $error("setup read upper bits set");
	a_sleep_cmd_sleeps: assert property (cmd == CMD_SLEEP |-> ##[1:2] asleep)
		else $error("sleep command ignored");
	a_asleep_no_drain: assert property (asleep ##1 asleep |-> cell_drain == '0)
		else $error("balancing while asleep");
	a_wake_clears_sleep: assert property (cmd == CMD_WAKE |=> !asleep)
		else $error("wake command ignored");
	a_inhibit_stops: assert property (cmd == CMD_BAL_INHIBIT |-> ##2 cell_drain == '0)
		else $error("inhibit left cells draining");
	a_flag_sticky: assert property (watchdog_expired_flag |=> watchdog_expired_flag)
		else $error("expired flag dropped");
endmodule : cbs_link_sva
`default_nettype wire

// [tb/tb.sv]
// Testbench joining host and device ends through the link.
// Assumes the short watchdog and second counts set below.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cbs_pkg::*;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic wdog_on = 1'b0;
	logic comm_ok = 1'b1;
	logic req_wr = 1'b0;
	logic req_rd = 1'b0;
	logic req_addr = 1'b0;
	logic req_bcast = 1'b0;
	logic [CELLS-1:0] req_wdata = 12'h000;
	logic [2:0] req_cmd = 3'h0;
	logic [CELLS-1:0] rsp_data;
	logic [CELLS-1:0] cell_drain;
	logic rsp_valid;
	logic asleep;
	logic watchdog_expired_flag;
	int err_count = 0;
	int num_checks = 0;
	always #10 mclk = ~mclk;
	cbs_link_if cbs_link_if_i();
	cbs_host cbs_host_i (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .req_wr(req_wr),
		.req_rd(req_rd), .req_addr(req_addr), .req_wdata(req_wdata), .req_cmd(req_cmd),
		.req_bcast(req_bcast), .comm_ok(comm_ok), .rsp_data(rsp_data),
		.rsp_valid(rsp_valid), .link(cbs_link_if_i));
	// Short counts keep the watchdog and auto steps within a few cycles
	cbs_device #(.WDOG_CYCLES(20), .SEC_CNT(4)) cbs_device_i (.mclk(mclk), .rst_b(rst_b),
		.clk_en(clk_en), .link(cbs_link_if_i), .wdog_on(wdog_on), .cell_drain(cell_drain),
		.asleep(asleep), .watchdog_expired_flag(watchdog_expired_flag));
	cbs_link_sva cbs_link_sva_i (.mclk(mclk), .rst_b(rst_b), .rd_en(cbs_link_if_i.rd_en),
		.addr(cbs_link_if_i.addr), .rdata(cbs_link_if_i.rdata), .rvalid(cbs_link_if_i.rvalid),
		.cmd(cbs_link_if_i.cmd), .cell_drain(cell_drain), .asleep(asleep),
		.watchdog_expired_flag(watchdog_expired_flag));
	// ********************
	// Tasks
	// ********************
	function automatic logic [11:0] sw(logic run, logic [3:0] idx, logic [1:0] kind);
		return {2'h0, run, idx, 3'h0, kind};
	endfunction : sw
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic cyc();
		@(posedge mclk);
		#2;
	endtask : cyc
	task automatic chk(logic [11:0] got, logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Waits on drain (sel 0), flag (1) or read answer (2)
	task automatic wt(int sel, logic [11:0] exp);
		logic [11:0] got;
		int n;
		n = 0;
		got = 12'h000;
		while (n < 80)
		begin
			got = sel == 0 ? cell_drain : {11'h0, sel == 1 ? watchdog_expired_flag : rsp_valid};
			if (got === exp)
				break;
			cyc();
			n++;
		end
		if (n == 80)
		begin
			$display("[FAIL] %0t wait ran out", $time);
			err_count++;
			print_verdict();
		end
	endtask : wt
	task automatic wr(logic a, logic [11:0] d);
		req_wr = 1'b1;
		req_addr = a;
		req_wdata = d;
		cyc();
		req_wr = 1'b0;
		repeat (3) cyc();
	endtask : wr
	task automatic rd(logic a, logic [11:0] exp);
		req_rd = 1'b1;
		req_addr = a;
		cyc();
		req_rd = 1'b0;
		wt(2, 12'h001);
		chk(rsp_data, exp);
		cyc();
	endtask : rd
	task automatic cm(logic [2:0] c);
		req_cmd = c;
		cyc();
		req_cmd = 3'h0;
		repeat (4) cyc();
	endtask : cm
	// ********************
	// Sequence
	// ********************
	initial
	begin
		repeat (6) @(posedge mclk);
		#2;
		rst_b = 1'b1;
		rd(ADDR_SETUP, 12'h000);
		rd(ADDR_PATTERN, 12'h000);
		for (int k = 0; k < 4; k++)
		begin
			wr(ADDR_SETUP, sw(1'b0, 4'h0, k[1:0]));
			rd(ADDR_SETUP, sw(1'b0, 4'h0, k[1:0]));
		end
		wr(ADDR_SETUP, sw(1'b0, 4'h0, KIND_MANUAL));
		wr(ADDR_PATTERN, 12'h010);
		wr(ADDR_SETUP, sw(1'b1, 4'h0, KIND_MANUAL));
		chk(cell_drain, 12'h010);
		rd(ADDR_SETUP, 12'h201);
		cm(CMD_BAL_INHIBIT);
		chk(cell_drain, 12'h000);
		rd(ADDR_SETUP, 12'h001);
		req_bcast = 1'b1;
		cm(CMD_BAL_ENABLE);
		chk(cell_drain, 12'h010);
		// Frozen enable: the command never leaves the host
		clk_en = 1'b0;
		cm(CMD_BAL_INHIBIT);
		clk_en = 1'b1;
		chk(cell_drain, 12'h010);
		cm(CMD_SLEEP);
		chk({cell_drain[10:0], asleep}, 12'h001);
		cm(CMD_WAKE);
		chk(cell_drain, 12'h010);
		$display("test manual done");
		wr(ADDR_SETUP, sw(1'b0, 4'hd, KIND_OFF));
		wr(ADDR_PATTERN, 12'hfff);
		rd(ADDR_PATTERN, 12'h000);
		wr(ADDR_SETUP, sw(1'b1, 4'h0, KIND_TIMED));
		chk(cell_drain, 12'h010);
		rd(ADDR_PATTERN, 12'h010);
		cm(CMD_BAL_INHIBIT);
		$display("test index done");
		wr(ADDR_SETUP, sw(1'b0, 4'h1, KIND_OFF));
		wr(ADDR_PATTERN, 12'h555);
		wr(ADDR_SETUP, sw(1'b0, 4'h2, KIND_OFF));
		wr(ADDR_PATTERN, 12'haaa);
		wr(ADDR_SETUP, sw(1'b1, 4'h1, KIND_AUTO));
		wt(0, 12'haaa);
		// Empty location 3 must never reach the cells: next is location 1
		for (int m = 0; m < 20 && cell_drain === 12'haaa; m++)
			cyc();
		chk(cell_drain, 12'h555);
		wt(0, 12'h555);
		wt(0, 12'haaa);
		cm(CMD_BAL_INHIBIT);
		$display("test auto done");
		wr(ADDR_SETUP, sw(1'b1, 4'h0, KIND_MANUAL));
		wdog_on = 1'b1;
		comm_ok = 1'b0;
		wt(1, 12'h001);
		repeat (2) cyc();
		chk({cell_drain[10:0], asleep}, 12'h001);
		rd(ADDR_SETUP, 12'h001);
		comm_ok = 1'b1;
		$display("test watchdog done");
		// Mid-run reset clears the sticky flag; link shows lost during it
		rst_b = 1'b0;
		cyc();
		rst_b = 1'b1;
		repeat (2) cyc();
		chk({cell_drain[9:0], asleep, watchdog_expired_flag}, 12'h000);
		wr(ADDR_PATTERN, 12'h010);
		wr(ADDR_SETUP, sw(1'b1, 4'h0, KIND_MANUAL));
		chk(cell_drain, 12'h010);
		cm(CMD_SLEEP);
		chk({cell_drain[9:0], asleep, watchdog_expired_flag}, 12'h002);
		comm_ok = 1'b0;
		wt(1, 12'h001);
		chk(cell_drain, 12'h000);
		comm_ok = 1'b1;
		$display("test sleep watchdog done");
		print_verdict();
	end
endmodule : tb
`default_nettype wire
